// File: logic/icp_config_port.sv
// Serial target port holding the 256 configuration registers and the store engine.
// Assumes the serial clock and data pins are asynchronous and far slower than the
// reference clock, and that the nonvolatile store answers on the reference clock.
`timescale 1ns/1ps

// Operation
// - Answer only when the received 7-bit target address equals 1101010.
// - Byte after the write command loads pointer; pointer steps after each data byte.
// - Direction bit 0 means write to device, 1 means read from device.
// - Register write is address, command ending 00, pointer, then data, all acknowledged.
// - Keep accepting write data until STOP, each byte to next register.
// - Read frame returns identification byte then registers; controller NACKs last byte.
// - Command ending 01 copies all registers into nonvolatile memory.
// - Command ending 10 loads all nonvolatile memory into registers.
// - Save or restore starts after STOP; no acknowledge until it completes.
// - Power-up performs a restore; address acknowledged once done.
// - Clock outputs held off until a restore has filled the registers.
module icp_config_port #(
  parameter logic [7:0] IDENTIFICATION_BYTE = 8'h5A // Arbitrary identification value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [7:0] i_cfg_addr,
  output logic [7:0] o_cfg_data,
  output logic o_clk_out_en,
  output logic o_busy,
  output logic o_nvm_rd,
  output logic o_nvm_wr,
  output logic [7:0] o_nvm_addr,
  output logic [7:0] o_nvm_wdata,
  input wire logic [7:0] i_nvm_rdata,
  input wire logic i_nvm_done
);

  // ==========================================================
  // Declarations
  logic [7:0] regs [icp_pkg::REG_COUNT];

  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  icp_pkg::icp_bus_t bus_st;
  icp_pkg::icp_phase_t phase;
  icp_pkg::icp_phase_t next_phase;
  icp_pkg::icp_eng_t eng_st;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  logic byte_full;
  logic ack_pend;
  logic next_ack;
  logic rd_dir;
  logic next_rd;
  logic mack_ok;
  logic byte_end;
  logic mack_take;
  logic sda_oe;

  logic [1:0] op_code;
  logic op_pend;
  logic op_req;
  logic eng_start;
  logic eng_save;
  logic eng_last;
  logic [7:0] eng_addr;
  logic [7:0] nvm_wdata;
  logic clk_en;
  logic [7:0] cfg_data;

  icp_pkg::icp_wr_t wr_in;
  icp_pkg::icp_wr_t wr_out;
  logic [icp_pkg::WBUF_WIDTH-1:0] wr_out_raw;
  logic wbuf_in_ready;
  logic wbuf_out_valid;
  logic wbuf_out_ready;
  logic wbuf_push;

  // Only the low two bits of the command carry meaning
  function automatic logic cmd_is(input logic [7:0] b, input logic [1:0] code);
    cmd_is = (b[1:0] == code);
  endfunction : cmd_is

  // ==========================================================
  // Pin synchronisers and bus conditions
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= i_sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign start_ev = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_ev = scl_sync & scl_prev & ~sda_prev & sda_sync;

  assign rx_byte = {shreg[6:0], sda_sync};
  assign byte_end = ~start_ev & ~stop_ev & scl_rise & (bus_st == icp_pkg::BUS_RX) & (bit_cnt == icp_pkg::BIT_LAST);
  assign mack_take = ~start_ev & ~stop_ev & scl_rise & (bus_st == icp_pkg::BUS_MACK) & ~sda_sync;

  // ==========================================================
  // Byte decision: acknowledge and next role
  always_comb begin
    next_ack = 1'b0;
    next_phase = phase;
    next_rd = rd_dir;
    unique case (phase)
      icp_pkg::PH_ADDR: begin
        next_ack = (rx_byte[7:1] == icp_pkg::TARGET_ADDR) & ~o_busy;
        next_rd = rx_byte[0];
        next_phase = icp_pkg::PH_CMD;
      end
      icp_pkg::PH_CMD: begin
        next_ack = 1'b1;
        next_phase = cmd_is(rx_byte, icp_pkg::CMD_WRITE) ? icp_pkg::PH_PTR : icp_pkg::PH_SKIP;
      end
      icp_pkg::PH_PTR: begin
        next_ack = 1'b1;
        next_phase = icp_pkg::PH_DATA;
      end
      icp_pkg::PH_DATA: begin
        // Full buffer refuses the byte rather than losing it
        next_ack = wbuf_in_ready;
      end
      icp_pkg::PH_SKIP: begin
        next_ack = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Bit-level target sequencer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_st <= icp_pkg::BUS_IDLE;
      phase <= icp_pkg::PH_ADDR;
      bit_cnt <= icp_pkg::BIT_FIRST;
      shreg <= icp_pkg::DATA_RESET;
      tx_byte <= icp_pkg::DATA_RESET;
      byte_full <= 1'b0;
      ack_pend <= 1'b0;
      rd_dir <= 1'b0;
      mack_ok <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      // Repeated start lands here too, so a pointer frame may run straight into a read
      bus_st <= icp_pkg::BUS_RX;
      phase <= icp_pkg::PH_ADDR;
      bit_cnt <= icp_pkg::BIT_FIRST;
      byte_full <= 1'b0;
      rd_dir <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      bus_st <= icp_pkg::BUS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (bus_st)
        icp_pkg::BUS_IDLE: begin
          sda_oe <= 1'b0;
        end
        icp_pkg::BUS_RX: begin
          if (scl_rise) begin
            shreg <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == icp_pkg::BIT_LAST) begin
              byte_full <= 1'b1;
              ack_pend <= next_ack;
              phase <= next_phase;
              rd_dir <= next_rd;
              if (phase == icp_pkg::PH_ADDR) begin
                tx_byte <= IDENTIFICATION_BYTE;
              end
            end
          end else if (scl_fall && byte_full) begin
            byte_full <= 1'b0;
            bus_st <= icp_pkg::BUS_ACK;
            sda_oe <= ack_pend;
          end
        end
        icp_pkg::BUS_ACK: begin
          if (scl_fall) begin
            bit_cnt <= icp_pkg::BIT_FIRST;
            if (!ack_pend) begin
              bus_st <= icp_pkg::BUS_IDLE;
              sda_oe <= 1'b0;
            end else if (rd_dir) begin
              bus_st <= icp_pkg::BUS_TX;
              sda_oe <= ~tx_byte[7];
            end else begin
              bus_st <= icp_pkg::BUS_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        icp_pkg::BUS_TX: begin
          if (scl_fall) begin
            if (bit_cnt == icp_pkg::BIT_LAST) begin
              bus_st <= icp_pkg::BUS_MACK;
              sda_oe <= 1'b0;
            end else begin
              bit_cnt <= bit_cnt + 3'h1;
              tx_byte <= {tx_byte[6:0], 1'b0};
              sda_oe <= ~tx_byte[6];
            end
          end
        end
        icp_pkg::BUS_MACK: begin
          if (scl_rise) begin
            mack_ok <= ~sda_sync;
            if (!sda_sync) begin
              tx_byte <= regs[ptr];
            end
          end else if (scl_fall) begin
            bit_cnt <= icp_pkg::BIT_FIRST;
            if (mack_ok) begin
              bus_st <= icp_pkg::BUS_TX;
              sda_oe <= ~tx_byte[7];
            end else begin
              // Controller NACK ends the read; wait for STOP or START
              bus_st <= icp_pkg::BUS_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe;

  // ==========================================================
  // Register pointer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr <= icp_pkg::PTR_RESET;
    end else if (byte_end && phase == icp_pkg::PH_PTR) begin
      ptr <= rx_byte;
    end else if ((byte_end && phase == icp_pkg::PH_DATA && wbuf_in_ready) || mack_take) begin
      ptr <= ptr + 8'h01;
    end
  end

  // ==========================================================
  // Write buffer between the serial side and the register file
  assign wbuf_push = byte_end & (phase == icp_pkg::PH_DATA) & wbuf_in_ready;
  assign wr_in = '{addr: ptr, data: rx_byte};
  assign wr_out = icp_pkg::icp_wr_t'(wr_out_raw);
  // Draining stalls while the store engine owns the register file
  assign wbuf_out_ready = (eng_st == icp_pkg::ENG_IDLE);

  icp_fifo #(
    .WIDTH(icp_pkg::WBUF_WIDTH),
    .DEPTH(icp_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(wbuf_push),
    .o_in_ready(wbuf_in_ready),
    .i_in_data(wr_in),
    .o_out_valid(wbuf_out_valid),
    .i_out_ready(wbuf_out_ready),
    .o_out_data(wr_out_raw)
  );

  // ==========================================================
  // Save and restore requests
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      op_code <= icp_pkg::CMD_WRITE;
      op_pend <= 1'b0;
      op_req <= 1'b0;
    end else begin
      if (start_ev) begin
        op_pend <= 1'b0;
      end else if (stop_ev && op_pend) begin
        op_pend <= 1'b0;
        op_req <= 1'b1;
      end else if (byte_end && phase == icp_pkg::PH_CMD) begin
        op_code <= rx_byte[1:0];
        op_pend <= cmd_is(rx_byte, icp_pkg::CMD_SAVE) | cmd_is(rx_byte, icp_pkg::CMD_RESTORE);
      end
      if (eng_start) begin
        op_req <= 1'b0;
      end
    end
  end

  // Pending buffered writes land before a save snapshots the registers
  assign eng_start = (eng_st == icp_pkg::ENG_IDLE) & op_req & ~wbuf_out_valid;
  assign eng_last = (eng_addr == icp_pkg::REG_LAST);

  // ==========================================================
  // Store engine, one byte per handshake
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      eng_st <= icp_pkg::ENG_LOAD;
      eng_save <= 1'b0;
      eng_addr <= icp_pkg::REG_FIRST;
      clk_en <= 1'b0;
    end else begin
      unique case (eng_st)
        icp_pkg::ENG_IDLE: begin
          if (eng_start) begin
            eng_st <= icp_pkg::ENG_LOAD;
            eng_save <= cmd_is({6'h00, op_code}, icp_pkg::CMD_SAVE);
            eng_addr <= icp_pkg::REG_FIRST;
            if (cmd_is({6'h00, op_code}, icp_pkg::CMD_RESTORE)) begin
              clk_en <= 1'b0;
            end
          end
        end
        icp_pkg::ENG_LOAD: begin
          eng_st <= icp_pkg::ENG_REQ;
        end
        icp_pkg::ENG_REQ: begin
          eng_st <= icp_pkg::ENG_WAIT;
        end
        icp_pkg::ENG_WAIT: begin
          if (i_nvm_done) begin
            if (eng_last) begin
              eng_st <= icp_pkg::ENG_IDLE;
              clk_en <= 1'b1;
            end else begin
              eng_addr <= eng_addr + 8'h01;
              eng_st <= icp_pkg::ENG_LOAD;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Register file: buffered writes and restored bytes
  always_ff @(posedge i_ref_clk) begin
    if (eng_st == icp_pkg::ENG_WAIT && i_nvm_done && !eng_save) begin
      regs[eng_addr] <= i_nvm_rdata;
    end else if (wbuf_out_valid && wbuf_out_ready) begin
      regs[wr_out.addr] <= wr_out.data;
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      nvm_wdata <= icp_pkg::DATA_RESET;
      cfg_data <= icp_pkg::DATA_RESET;
    end else begin
      if (eng_st == icp_pkg::ENG_LOAD) begin
        nvm_wdata <= regs[eng_addr];
      end
      cfg_data <= regs[i_cfg_addr];
    end
  end

  assign o_nvm_rd = (eng_st == icp_pkg::ENG_REQ) & ~eng_save;
  assign o_nvm_wr = (eng_st == icp_pkg::ENG_REQ) & eng_save;
  assign o_nvm_addr = eng_addr;
  assign o_nvm_wdata = nvm_wdata;
  assign o_cfg_data = cfg_data;
  assign o_clk_out_en = clk_en;
  assign o_busy = (eng_st != icp_pkg::ENG_IDLE) | op_req;

endmodule : icp_config_port

// File: shared/icp_pkg.sv
// Package for the configuration port: bus address, command codes, states, carriers.
// Assumes one 100 MHz reference clock; the serial clock arrives as a plain input.
package icp_pkg;

  // ==========================================================
  // Bus constants
  localparam logic [6:0] TARGET_ADDR = 7'h6A;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_SAVE = 2'h1;
  localparam logic [1:0] CMD_RESTORE = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // ==========================================================
  // Register file and store sequencing
  localparam logic [7:0] REG_FIRST = 8'h00;
  localparam logic [7:0] REG_LAST = 8'hFF;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int REG_COUNT = 256;

  // ==========================================================
  // Write buffer shape
  localparam int WBUF_DEPTH = 32;
  localparam int WBUF_WIDTH = 16;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } icp_wr_t;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_ACK,
    BUS_TX,
    BUS_MACK
  } icp_bus_t;

  typedef enum logic [2:0] {
    PH_ADDR,
    PH_CMD,
    PH_PTR,
    PH_DATA,
    PH_SKIP
  } icp_phase_t;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_LOAD,
    ENG_REQ,
    ENG_WAIT
  } icp_eng_t;

endpackage : icp_pkg

// File: logic/icp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the reference clock.
`timescale 1ns/1ps
module icp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // ==========================================================
  // Storage
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // ==========================================================
  // Pointers and fill level
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : icp_fifo

// File: test/icp_config_port_asserts.sv
// Checker for the configuration port: store sequencing, busy window, output gating.
// Assumes it is bound to icp_config_port and sees only that module's ports.
`timescale 1ns/1ps
module icp_config_port_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic o_sda_oe,
  input wire logic o_clk_out_en,
  input wire logic o_busy,
  input wire logic o_nvm_rd,
  input wire logic o_nvm_wr,
  input wire logic [7:0] o_nvm_addr,
  input wire logic [7:0] o_nvm_wdata,
  input wire logic i_nvm_done
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // Helper: last store address requested
  logic req;
  logic [7:0] last_req;
  assign req = o_nvm_rd || o_nvm_wr;
  // Starts at the top so every pass must begin at byte 0
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      last_req <= 8'hFF;
    end else if (req) begin
      last_req <= o_nvm_addr;
    end
  end
  // ==========
  // Properties
  AST_REQ_EXCL: assert property (!(o_nvm_rd && o_nvm_wr)) else $error("store read and write together");
  AST_REQ_ONE: assert property (req |=> !req) else $error("store request longer than a cycle");
  AST_ADDR_STEP: assert property (req |-> o_nvm_addr == last_req + 8'h01)
    else $error("store address did not step by one");
  AST_HOLD: assert property (req |=> $stable(o_nvm_addr) && $stable(o_nvm_wdata))
    else $error("store address or data moved while pending");
  AST_NEXT_REQ: assert property (i_nvm_done && o_busy && o_nvm_addr != 8'hFF |-> ##[1:3] req)
    else $error("store pass stopped before the last byte");
  AST_BUSY_END: assert property ($fell(o_busy) |-> ($past(i_nvm_done) || $past(i_nvm_done, 2))
    && $past(o_nvm_addr) == 8'hFF) else $error("busy ended before byte 255 completed");
  AST_REQ_BUSY: assert property (req |-> o_busy) else $error("store access while not busy");
  AST_NO_ACK_BUSY: assert property (o_busy |-> !o_sda_oe) else $error("acknowledge while busy");
  AST_RESTORE_OFF: assert property (o_nvm_rd |-> !o_clk_out_en) else $error("clocks on during restore");
  AST_EN_AFTER: assert property ($fell(o_busy) |-> ##[0:2] o_clk_out_en)
    else $error("clocks not enabled after store pass");
endmodule : icp_config_port_asserts

bind icp_config_port icp_config_port_asserts chk_u (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .o_sda_oe(o_sda_oe),
  .o_clk_out_en(o_clk_out_en),
  .o_busy(o_busy),
  .o_nvm_rd(o_nvm_rd),
  .o_nvm_wr(o_nvm_wr),
  .o_nvm_addr(o_nvm_addr),
  .o_nvm_wdata(o_nvm_wdata),
  .i_nvm_done(i_nvm_done)
);

// File: test/icp_ctl_model.sv
// Serial bus controller model: SCL and an SDA pull-down, 160 ns per bit.
// Assumes the bench resolves SDA with a pull-up and returns it on i_sda.
`timescale 1ns/1ps
module icp_ctl_model (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // SCL stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ==========
  // Bit timing, moved on falling reference edges
  task automatic q();
    repeat (4) @(negedge i_ref_clk);
  endtask : q
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = !b;
    q();
    o_scl = 1'b1;
    q();
    s = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask : bit_io
  // ==========
  // Conditions; start also serves as repeated START
  task automatic start();
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask : stop
  // ==========
  // Bytes, most significant bit first
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(!more, s);
  endtask : rbyte
endmodule : icp_ctl_model

// File: test/icp_config_port_tb.sv
// Self-checking bench: controller model on the serial pins, behavioural store behind
// the store port, registers read back on the side port. Assumes a 100 MHz clock.
`timescale 1ns/1ps
module icp_config_port_tb;
  localparam logic [7:0] ID_EXP = 8'h5A; // Arbitrary identification value
  logic clk, rst, scl, sda_low, sda_out, sda_oe, clk_en, busy, nvm_rd, nvm_wr, nvm_done, w_q;
  logic [7:0] cfg_addr, cfg_data, nvm_addr, nvm_wdata, nvm_rdata, a_q, d_q;
  logic [7:0] mem [256];
  int n_mismatch, comparisons, cycles, nvm_reqs;
  wire sda = !(sda_low || (sda_oe && !sda_out));
  icp_config_port #(.IDENTIFICATION_BYTE(ID_EXP)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_cfg_addr(cfg_addr), .o_cfg_data(cfg_data),
    .o_clk_out_en(clk_en), .o_busy(busy), .o_nvm_rd(nvm_rd), .o_nvm_wr(nvm_wr), .o_nvm_addr(nvm_addr),
    .o_nvm_wdata(nvm_wdata), .i_nvm_rdata(nvm_rdata), .i_nvm_done(nvm_done));
  icp_ctl_model ctl_u (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // Store model: prompt on even bytes, slow on odd ones
  initial begin
    nvm_done = 1'b0;
    nvm_rdata = 8'h00;
    forever begin
      @(negedge clk);
      if (nvm_rd || nvm_wr) begin
        nvm_reqs++;
        a_q = nvm_addr;
        w_q = nvm_wr;
        d_q = nvm_wdata;
        // Done lands at least one cycle after the request, while the engine waits for it
        repeat (a_q[0] ? 3 : 1) @(negedge clk);
        if (w_q) mem[a_q] = d_q;
        nvm_rdata = mem[a_q];
        nvm_done = 1'b1;
        @(negedge clk);
        nvm_done = 1'b0;
        nvm_rdata = ~nvm_rdata; // Stale data must not pass for valid
      end
    end
  end
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic [7:0] b, input logic exp_ack, input string what);
    logic a;
    ctl_u.wbyte(b, a);
    check(what, {7'h00, a}, {7'h00, exp_ack});
  endtask : xfer
  task automatic peek(input logic [7:0] a, input logic [7:0] exp, input string what);
    cfg_addr = a;
    repeat (2) @(negedge clk);
    check(what, cfg_data, exp);
  endtask : peek
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    check("busy", {7'h00, busy}, 8'h00);
  endtask : wait_idle
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ==========
  // Scenarios
  task automatic t_powerup();
    check("clk_en at reset", {7'h00, clk_en}, 8'h00);
    wait_idle();
    check("clk_en", {7'h00, clk_en}, 8'h01);
    for (int i = 0; i < 256; i++) peek(8'(i), mem[i], "restored reg");
    $display("powerup done");
  endtask : t_powerup
  task automatic t_addr();
    ctl_u.start();
    xfer(8'hD6, 1'b0, "ack other addr");
    ctl_u.stop();
    ctl_u.start();
    xfer(8'h54, 1'b0, "ack other addr");
    ctl_u.stop();
    $display("address done");
  endtask : t_addr
  task automatic t_write();
    ctl_u.start();
    xfer(8'hD4, 1'b1, "ack addr");
    xfer(8'hFC, 1'b1, "ack cmd");
    xfer(8'hFE, 1'b1, "ack ptr");
    for (int i = 0; i < 3; i++) xfer(8'h30 + 8'(i), 1'b1, "ack data");
    ctl_u.stop();
    peek(8'hFE, 8'h30, "reg FE");
    peek(8'hFF, 8'h31, "reg FF");
    peek(8'h00, 8'h32, "reg 00");
    $display("write done");
  endtask : t_write
  task automatic t_read();
    logic [7:0] d;
    ctl_u.start();
    xfer(8'hD4, 1'b1, "ack addr");
    xfer(8'h00, 1'b1, "ack cmd");
    xfer(8'hFE, 1'b1, "ack ptr");
    ctl_u.start();
    xfer(8'hD5, 1'b1, "ack read addr");
    ctl_u.rbyte(1'b1, d);
    check("identification_byte", d, ID_EXP);
    for (int i = 0; i < 3; i++) begin
      ctl_u.rbyte(i < 2, d);
      check("read reg", d, 8'h30 + 8'(i));
    end
    ctl_u.stop();
    $display("read done");
  endtask : t_read
  task automatic t_save();
    ctl_u.start();
    xfer(8'hD4, 1'b1, "ack addr");
    xfer(8'h01, 1'b1, "ack save");
    ctl_u.stop();
    check("busy after stop", {7'h00, busy}, 8'h01);
    ctl_u.start();
    xfer(8'hD4, 1'b0, "ack while busy");
    ctl_u.stop();
    wait_idle();
    check("saved FE", mem[8'hFE], 8'h30);
    check("saved 00", mem[8'h00], 8'h32);
    check("saved 01", mem[8'h01], 8'hA4);
    $display("save done");
  endtask : t_save
  task automatic t_restore();
    mem[8'h20] = 8'h77;
    mem[8'hFE] = 8'h99;
    ctl_u.start();
    xfer(8'hD4, 1'b1, "ack addr");
    xfer(8'hFE, 1'b1, "ack restore");
    ctl_u.stop();
    repeat (4) @(negedge clk);
    check("clk_en in restore", {7'h00, clk_en}, 8'h00);
    wait_idle();
    peek(8'h20, 8'h77, "restored 20");
    peek(8'hFE, 8'h99, "restored FE");
    check("clk_en after", {7'h00, clk_en}, 8'h01);
    $display("restore done");
  endtask : t_restore
  task automatic t_code11();
    int reqs;
    reqs = nvm_reqs;
    ctl_u.start();
    xfer(8'hD4, 1'b1, "ack addr");
    xfer(8'h03, 1'b1, "ack code 11");
    xfer(8'h55, 1'b0, "ack after code 11");
    ctl_u.stop();
    repeat (8) @(negedge clk);
    check("busy code 11", {7'h00, busy}, 8'h00);
    check("store requests", 8'(nvm_reqs - reqs), 8'h00);
    peek(8'h55, 8'hF0, "reg 55");
    $display("code 11 done");
  endtask : t_code11
  // ==========
  // Main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    cfg_addr = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_powerup();
    t_addr();
    t_write();
    t_read();
    t_save();
    t_restore();
    t_code11();
    tally_and_finish();
  end
endmodule : icp_config_port_tb
